// ### edge_triggered_oneshot_timer.v
// Edge-triggered one-shot period timer with PWM drive
//
// What this block does
// - After run is set, wait idle until a qualifying trigger edge.
// - On count equal to period value, clear own run bit.
// - Mode 01001 rising, 01010 falling, 01011 either edge starts the timer.
// - Run cleared then set again needs a fresh trigger edge to count.
// - Starting trigger edge asserts the PWM drive output.
// - PWM drops at pulse-width match, stays low after period halt.
`timescale 1ns/1ps
`default_nettype none
`include "oneshot_timer_defines.vh"
module edge_triggered_oneshot_timer (
	input wire clk_in, // 100 MHz clock
	input wire rst_n_in, // Async reset, active low
	input wire ce_in, // Clock enable, freezes state when low
	input wire run_set_in, // Pulse: software sets run bit
	input wire run_clr_in, // Pulse: software clears run bit
	input wire [`OST_MODE_W-1:0] mode_in, // Mode field
	input wire [`OST_CNT_W-1:0] period_value_register_in, // Period value
	input wire [`OST_CNT_W-1:0] pulse_width_compare_value_in, // PWM pulse width
	input wire external_trigger_source_in, // External trigger pin
	output reg run_out, // Run bit state
	output reg counting_out, // Timer is counting
	output reg [`OST_CNT_W-1:0] count_out, // Current count
	output reg period_match_out, // One-cycle pulse on period halt
	output reg pwm_drive_out // PWM drive to compare unit
);
	// State codes of the one-shot sequencer
	localparam [1:0] ST_OFF = 2'b00;
	localparam [1:0] ST_ARMED = 2'b01;
	localparam [1:0] ST_COUNT = 2'b10;

	reg [1:0] state_ff;
	reg [1:0] nxt_state;
	reg [`OST_CNT_W-1:0] nxt_count;
	reg nxt_pwm;
	reg nxt_match;
	reg nxt_run;
	reg nxt_counting;
	wire trig_edge;
	wire mode_ok;
	wire start_evt;
	wire stop_evt;
	wire period_hit;
	wire width_hit;

	// True for the three edge-start mode codes
	function mode_valid;
		input [`OST_MODE_W-1:0] mode;
		begin
			case (mode)
				`OST_MODE_RISE: mode_valid = 1'b1;
				`OST_MODE_FALL: mode_valid = 1'b1;
				`OST_MODE_BOTH: mode_valid = 1'b1;
				default: mode_valid = 1'b0;
			endcase
		end
	endfunction

	// Count against a compare value
	function count_hit;
		input [`OST_CNT_W-1:0] cnt;
		input [`OST_CNT_W-1:0] ref_val;
		begin
			count_hit = (cnt == ref_val);
		end
	endfunction

	// Wraps at the counter width on purpose
	function [`OST_CNT_W-1:0] count_inc;
		input [`OST_CNT_W-1:0] cnt;
		begin
			count_inc = cnt + 8'h01;
		end
	endfunction

	assign mode_ok = mode_valid(mode_in);
	// start needs armed state and edge
	assign start_evt = (state_ff == ST_ARMED) && trig_edge && mode_ok && !run_clr_in;
	// Clear wins over set and over a start
	assign stop_evt = run_clr_in;
	assign period_hit = (state_ff == ST_COUNT) && count_hit(count_out, period_value_register_in);
	assign width_hit = (state_ff == ST_COUNT) && count_hit(count_out, pulse_width_compare_value_in);

	trig_edge_detect u_edge (
		.clk_in(clk_in),
		.rst_n_in(rst_n_in),
		.ce_in(ce_in),
		.trig_in(external_trigger_source_in),
		.mode_in(mode_in),
		.edge_out(trig_edge)
	);

	// Sequencer: off, armed, counting
	always @* begin
		nxt_state = state_ff;
		case (state_ff)
			ST_OFF: begin
				// rearm waits for a new edge
				if (run_set_in && !stop_evt) begin
					nxt_state = ST_ARMED;
				end
			end
			ST_ARMED: begin
				if (stop_evt) begin
					nxt_state = ST_OFF;
				end else if (start_evt) begin
					nxt_state = ST_COUNT;
				end
			end
			ST_COUNT: begin
				if (stop_evt || period_hit) begin
					nxt_state = ST_OFF;
				end
			end
			default: begin
				nxt_state = ST_OFF;
			end
		endcase
	end

	// Counter: kept on a clear, restarts from zero
	always @* begin
		nxt_count = count_out;
		if (start_evt) begin
			nxt_count = `OST_CNT_RST;
		end else if ((state_ff == ST_COUNT) && !stop_evt) begin
			if (period_hit) begin
				nxt_count = `OST_CNT_RST;
			end else begin
				nxt_count = count_inc(count_out);
			end
		end
	end

	// PWM drive
	always @* begin
		nxt_pwm = pwm_drive_out;
		if (start_evt) begin
			nxt_pwm = 1'b1;
		end else if (state_ff == ST_COUNT) begin
			// drop on width, low after halt
			if (stop_evt || period_hit || width_hit) begin
				nxt_pwm = 1'b0;
			end
		end else if (state_ff != ST_ARMED) begin
			nxt_pwm = 1'b0;
		end
	end

	// Halt pulse and status flags
	always @* begin
		nxt_match = 1'b0;
		if (period_hit && !stop_evt) begin
			nxt_match = 1'b1;
		end
		nxt_run = (nxt_state != ST_OFF);
		nxt_counting = (nxt_state == ST_COUNT);
	end

	// Registers, all frozen while ce_in is low
	always @(posedge clk_in or negedge rst_n_in) begin
		if (!rst_n_in) begin
			state_ff <= ST_OFF;
		end else if (ce_in) begin
			state_ff <= nxt_state;
		end
	end

	always @(posedge clk_in or negedge rst_n_in) begin
		if (!rst_n_in) begin
			count_out <= `OST_CNT_RST;
		end else if (ce_in) begin
			count_out <= nxt_count;
		end
	end

	always @(posedge clk_in or negedge rst_n_in) begin
		if (!rst_n_in) begin
			pwm_drive_out <= 1'b0;
		end else if (ce_in) begin
			pwm_drive_out <= nxt_pwm;
		end
	end

	always @(posedge clk_in or negedge rst_n_in) begin
		if (!rst_n_in) begin
			period_match_out <= 1'b0;
		end else if (ce_in) begin
			period_match_out <= nxt_match;
		end
	end

	// run bit clears itself on halt
	always @(posedge clk_in or negedge rst_n_in) begin
		if (!rst_n_in) begin
			run_out <= 1'b0;
		end else if (ce_in) begin
			run_out <= nxt_run;
		end
	end

	always @(posedge clk_in or negedge rst_n_in) begin
		if (!rst_n_in) begin
			counting_out <= 1'b0;
		end else if (ce_in) begin
			counting_out <= nxt_counting;
		end
	end
endmodule
`default_nettype wire

// ### edge_triggered_oneshot_timer_tb_top.sv
// Random one-shot runs with pwm width check
`timescale 1ns/1ps
`default_nettype none
module edge_triggered_oneshot_timer_tb_top;
reg clk = 0, rst_n = 0, ss = 0, sc = 0, lvl = 0, ce = 1;
reg [4:0] md = 5'h09;
reg [7:0] p = 0, w = 0;
wire pin, run, cnt, pm, pwm;
wire [7:0] cv;
integer seed = 32'h00709ae6, n_fail = 0, tests_run = 0, i, k, hi;
trig_source_model src (.clk_in(clk), .lvl_in(lvl), .pin_out(pin));
edge_triggered_oneshot_timer uut (.clk_in(clk), .rst_n_in(rst_n), .ce_in(ce), .run_set_in(ss),
	.run_clr_in(sc), .mode_in(md), .period_value_register_in(p), .pulse_width_compare_value_in(w),
	.external_trigger_source_in(pin), .run_out(run), .counting_out(cnt), .count_out(cv),
	.period_match_out(pm), .pwm_drive_out(pwm));
function integer exp_hi(input [7:0] pp, input [7:0] ww);
	exp_hi = (ww < pp) ? ww + 1 : pp + 1;
endfunction
task chk(input [31:0] g, input [31:0] e);
	begin
		tests_run = tests_run + 1;
		if (g !== e) begin
			n_fail = n_fail + 1;
			$display("MISMATCH %0t %h %h", $time, g, e);
		end
	end
endtask
task finish_test;
	begin
		if (n_fail == 0 && tests_run > 0) $display("verification passed");
		else $display("verification failed");
		$finish;
	end
endtask
initial forever #5 clk = ~clk;
initial begin
	#500000;
	n_fail = n_fail + 1;
	finish_test;
end
initial begin
	repeat (10) @(posedge clk);
	rst_n <= 1;
	for (i = 0; i < 40; i = i + 1) begin
		@(posedge clk);
		md <= 5'h09 + $unsigned($random(seed)) % 3;
		// Corner cases first: zero period, equal, width past period
		case (i)
			0: begin
				p <= 8'h00;
				w <= 8'h00;
			end
			1: begin
				p <= 8'h05;
				w <= 8'h05;
			end
			2: begin
				p <= 8'h03;
				w <= 8'h1f;
			end
			default: begin
				p <= $random(seed) & 8'h1f;
				w <= $random(seed) & 8'h1f;
			end
		endcase
		@(posedge clk);
		lvl <= (md == 5'h0a);
		repeat (6) @(posedge clk);
		// Enable low freezes the run bit
		ce <= 0;
		ss <= 1;
		@(posedge clk);
		ss <= 0;
		#1 chk(run, 0);
		@(posedge clk);
		ce <= 1;
		ss <= 1;
		@(posedge clk);
		ss <= 0;
		// Stop then re-arm
		if (i[0]) begin
			sc <= 1;
			@(posedge clk);
			sc <= 0;
			ss <= 1;
			@(posedge clk);
			ss <= 0;
		end
		repeat (8) @(posedge clk);
		#1 chk(cnt, 0);
		chk(run, 1);
		@(posedge clk);
		lvl <= ~lvl;
		hi = 0;
		for (k = 0; k < 600 && pm !== 1; k = k + 1) begin
			@(posedge clk);
			#1 hi = hi + pwm;
		end
		chk(hi, exp_hi(p, w));
		chk(run, 0);
		chk(cnt, 0);
		chk(cv, 0);
		@(posedge clk);
		#1 chk(pm, 0);
	end
	// Invalid mode never starts
	@(posedge clk);
	md <= 5'h00;
	ss <= 1;
	@(posedge clk);
	ss <= 0;
	lvl <= ~lvl;
	repeat (12) @(posedge clk);
	#1 chk(cnt, 0);
	chk(run, 1);
	// Clear while counting, then re-arm
	@(posedge clk);
	sc <= 1;
	md <= 5'h0b;
	p <= 8'hff;
	w <= 8'hff;
	@(posedge clk);
	sc <= 0;
	ss <= 1;
	@(posedge clk);
	ss <= 0;
	lvl <= ~lvl;
	repeat (10) @(posedge clk);
	#1 chk(cnt, 1);
	chk(pwm, 1);
	@(posedge clk);
	sc <= 1;
	@(posedge clk);
	sc <= 0;
	ss <= 1;
	@(posedge clk);
	ss <= 0;
	repeat (10) @(posedge clk);
	#1 chk(cnt, 0);
	chk(pwm, 0);
	chk(run, 1);
	finish_test;
end
endmodule
`default_nettype wire

// ### oneshot_timer_defines.vh
// Constants for the edge-triggered one-shot timer
`ifndef ONESHOT_TIMER_DEFINES_VH
`define ONESHOT_TIMER_DEFINES_VH
`define OST_CNT_W 8
`define OST_MODE_W 5
`define OST_MODE_RISE 5'h09
`define OST_MODE_FALL 5'h0a
`define OST_MODE_BOTH 5'h0b
`define OST_CNT_RST 8'h00
`define OST_ST_OFF 2'h0
`define OST_ST_ARMED 2'h1
`define OST_ST_COUNT 2'h2
`endif

// ### oneshot_timer_monitor.sv
// Port assertions for the one-shot timer
`timescale 1ns/1ps
`default_nettype none
module oneshot_timer_monitor(
	input wire clk_in,
	input wire rst_n_in,
	input wire [4:0] mode_in,
	input wire [7:0] period_value_register_in,
	input wire [7:0] pulse_width_compare_value_in,
	input wire run_out,
	input wire counting_out,
	input wire [7:0] count_out,
	input wire period_match_out,
	input wire pwm_drive_out
);
default clocking @(posedge clk_in); endclocking
default disable iff (!rst_n_in);
sequence s_start;
	$rose(counting_out);
endsequence
a_start_armed: assert property (s_start |-> $past(run_out)) else $error("start unarmed");
a_rearm_idle: assert property ($rose(run_out) |-> !counting_out) else $error("resumed");
a_mode_valid: assert property (s_start |-> mode_in inside {5'h09, 5'h0a, 5'h0b}) else $error("bad mode");
a_pwm_start: assert property (s_start |-> pwm_drive_out && count_out == 8'h00) else $error("no pwm");
a_period_halt: assert property (counting_out && count_out == period_value_register_in
	|=> period_match_out && !run_out) else $error("no halt");
a_pwm_drop: assert property (counting_out && count_out == pulse_width_compare_value_in
	|=> !pwm_drive_out) else $error("pwm held");
a_count_clear: assert property (period_match_out |-> count_out == 8'h00 && !pwm_drive_out) else $error("no clear");
endmodule
bind edge_triggered_oneshot_timer oneshot_timer_monitor mon (.*);
`default_nettype wire

// ### trig_edge_detect.v
// Trigger pin synchroniser and edge qualifier
`timescale 1ns/1ps
`default_nettype none
`include "oneshot_timer_defines.vh"
module trig_edge_detect (
	input wire clk_in, // System clock
	input wire rst_n_in, // Async reset, active low
	input wire ce_in, // Clock enable
	input wire trig_in, // Raw external trigger pin
	input wire [`OST_MODE_W-1:0] mode_in, // Edge select mode
	output reg edge_out // Qualifying edge, one cycle
);
	reg sync1_ff;
	reg sync2_ff;
	reg sync3_ff;
	reg level_ff;
	wire agree;
	wire rise;
	wire fall;
	assign agree = (sync2_ff == sync3_ff);
	assign rise = agree && sync2_ff && !level_ff;
	assign fall = agree && !sync2_ff && level_ff;
	always @(posedge clk_in or negedge rst_n_in) begin
		if (!rst_n_in) begin
			sync1_ff <= 1'b0;
			sync2_ff <= 1'b0;
			sync3_ff <= 1'b0;
			level_ff <= 1'b0;
			edge_out <= 1'b0;
		end else if (ce_in) begin
			sync1_ff <= trig_in;
			sync2_ff <= sync1_ff;
			sync3_ff <= sync2_ff;
			if (agree) begin
				level_ff <= sync2_ff;
			end
			case (mode_in)
				`OST_MODE_RISE: edge_out <= rise;
				`OST_MODE_FALL: edge_out <= fall;
				`OST_MODE_BOTH: edge_out <= rise | fall;
				default: edge_out <= 1'b0;
			endcase
		end
	end
endmodule
`default_nettype wire

// ### trig_source_model.sv
// Trigger source driving the external pin
`timescale 1ns/1ps
`default_nettype none
module trig_source_model(
	input wire logic clk_in, // Bench clock
	input wire logic lvl_in, // Requested level
	output var logic pin_out // Pin, moves off edge
);
initial pin_out = 1'b0;
always @(posedge clk_in) pin_out <= #3 lvl_in;
endmodule
`default_nettype wire
